// [rtl/frame_scrambler.sv]
`timescale 1ns/1ps
module frame_scrambler
  import sonet_soh_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reload,
  input wire logic advance,
  input wire logic [7:0] din,
  output logic [7:0] dout
);

  typedef struct packed {
    logic [6:0] lfsr;
  } scr_state_t;

  scr_state_t st_ff;
  scr_state_t nxt_st;

  // frame synchronous x^7 + x^6 + 1, msb first; returns {next state, key byte}
  function automatic logic [14:0] key_step(input logic [6:0] seed);
    logic [6:0] s;
    logic [7:0] k;
    s = seed;
    k = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      k[i] = s[6];
      s = {s[5:0], s[6] ^ s[5]};
    end
    return {s, k};
  endfunction

  logic [14:0] step;

  always_comb
  begin
    step = key_step(st_ff.lfsr);
    dout = din ^ step[7:0];
    nxt_st = st_ff;
    if (reload)
    begin
      nxt_st.lfsr = SCRAMBLER_SEED;
    end
    else if (advance)
    begin
      nxt_st.lfsr = step[14:8];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '{lfsr: SCRAMBLER_SEED};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule

// [rtl/sonet_section_overhead_ctrl.sv]
// Operation
// R1: loss-of-signal status bit follows the receive processor's loss-of-signal state.
// R2: declare loss of frame only after out-of-frame lasts longer than 3 ms.
// R3: loss of frame clears only after in-frame lasts longer than 3 ms.
// R4: out-of-frame status bit follows the receive processor's out-of-frame state.
// R5: about 1 us after writing count registers or offset 00h, snapshot the count.
// R6: the internal B1 counter clears to zero at the snapshot moment.
// R7: software reads both count registers after a snapshot; valid unless overflowed.
// R8: count bits 7..0 at the low register, 15..8 at the next; reset zero.
// R9: scramble transmit stream when scramble-disable is 0, send plain when 1.
// R10: line AIS forces all non-section-overhead bits to one before scrambling.
// R11: AIS insertion starts or stops only at a transmit frame boundary.
// R12: forced signal loss drives transmit data to all zeros.
// R13: B1 inversion inverts the transmitted B1 byte in every frame.
// R14: framing error clears the msb of the first A1 byte.
// R15: internal B1 counter saturates at all ones instead of wrapping.
`timescale 1ns/1ps
module sonet_section_overhead_ctrl
  import sonet_soh_pkg::*;
#(
  parameter int lof_cycles = LOF_PERSIST_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rx_signal_loss,
  input wire logic rx_out_of_frame,
  input wire logic rx_b1_err_valid,
  input wire logic [3:0] rx_b1_err_bits,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_frame_start,
  input wire logic tx_soh,
  input wire logic tx_no_scramble,
  input wire logic tx_b1_slot,
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  output logic signal_loss_status,
  output logic frame_loss_status,
  output logic out_of_frame_status
);

  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [5:0] aw_idx;
    logic wready;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] tx_control;
    logic [7:0] error_insert;
    logic [15:0] section_parity_error_count;
    logic [15:0] b1_accum;
    logic snap_pending;
    logic [SNAP_TIMER_W-1:0] snap_timer;
    logic signal_loss_status;
    logic out_of_frame_status;
    logic frame_loss_status;
    logic [LOF_TIMER_W-1:0] lof_timer;
    logic ais_active;
    logic [7:0] bip_running;
    logic [7:0] bip_last;
    logic tx_out_valid;
    logic [7:0] tx_out_data;
  } ctrl_state_t;

  localparam logic [LOF_TIMER_W-1:0] LOF_LIMIT = LOF_TIMER_W'(lof_cycles);

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;

  // the internal count never wraps, so an overflowed interval reads as all ones
  function automatic logic [15:0] sat_add(input logic [15:0] acc, input logic [3:0] inc);
    logic [16:0] sum;
    sum = {1'b0, acc} + {13'h0000, inc};
    return sum[16] ? COUNT_MAX : sum[15:0];
  endfunction

  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

  logic [7:0] tx_byte;
  logic [7:0] tx_scrambled;
  logic scr_reload;
  logic scr_advance;

  frame_scrambler scrambler
  (
    .clock(clock),
    .rst(rst),
    .reload(scr_reload),
    .advance(scr_advance),
    .din(tx_byte),
    .dout(tx_scrambled)
  );

  logic snap_fire;
  logic ais_now;
  logic [7:0] tx_final;
  logic [7:0] read_value;
  logic read_hit;

  always_comb
  begin
    nxt_st = st_ff;
    snap_fire = 1'b0;
    read_value = 8'h00;
    read_hit = 1'b1;

    // write address and data are taken independently, in either order
    if (awvalid && st_ff.awready)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_idx = word_index(awaddr);
    end
    if (wvalid && st_ff.wready)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = wdata[7:0];
      nxt_st.w_lane0 = wstrb[0];
    end
    if (st_ff.bvalid && bready)
    begin
      nxt_st.bvalid = 1'b0;
    end

    // snapshot timer runs first so that a fresh trigger below restarts it
    if (st_ff.snap_pending)
    begin
      if (st_ff.snap_timer == '0)
      begin
        snap_fire = 1'b1;
        nxt_st.snap_pending = 1'b0;
      end
      else
      begin
        nxt_st.snap_timer = st_ff.snap_timer - 1'b1;
      end
    end

    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      unique case (st_ff.aw_idx)
        IDX_MASTER, IDX_COUNT_LOW, IDX_COUNT_HIGH:
        begin
          nxt_st.snap_pending = 1'b1; // R5
          nxt_st.snap_timer = SNAP_TIMER_LOAD; // R5
        end
        IDX_TX_CONTROL:
        begin
          if (st_ff.w_lane0)
          begin
            nxt_st.tx_control = st_ff.w_data & TX_CONTROL_MASK;
          end
        end
        IDX_ERROR_INSERT:
        begin
          if (st_ff.w_lane0)
          begin
            nxt_st.error_insert = st_ff.w_data & ERROR_INSERT_MASK;
          end
        end
        IDX_RX_STATUS:
        begin
          nxt_st.bresp = RESP_OKAY;
        end
        default:
        begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // one read at a time; data comes the cycle after the address is taken
    if (st_ff.rvalid && rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && st_ff.arready)
    begin
      unique case (word_index(araddr))
        IDX_MASTER: read_value = 8'h00;
        IDX_RX_STATUS:
        begin
          read_value[STATUS_LOS_BIT] = st_ff.signal_loss_status; // R1
          read_value[STATUS_LOF_BIT] = st_ff.frame_loss_status; // R2 R3
          read_value[STATUS_OOF_BIT] = st_ff.out_of_frame_status; // R4
        end
        IDX_COUNT_LOW: read_value = st_ff.section_parity_error_count[7:0]; // R8 R7
        IDX_COUNT_HIGH: read_value = st_ff.section_parity_error_count[15:8]; // R8 R7
        IDX_TX_CONTROL: read_value = st_ff.tx_control;
        IDX_ERROR_INSERT: read_value = st_ff.error_insert;
        default: read_hit = 1'b0;
      endcase
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = {24'h000000, read_value};
      nxt_st.rresp = read_hit ? RESP_OKAY : RESP_SLVERR;
    end

    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;

    // B1 error accumulation; an error in the snapshot cycle opens the new interval
    if (snap_fire)
    begin
      nxt_st.section_parity_error_count = st_ff.b1_accum; // R5 R8
      nxt_st.b1_accum = COUNT_RESET; // R6
    end
    if (rx_b1_err_valid)
    begin
      nxt_st.b1_accum = sat_add(nxt_st.b1_accum, rx_b1_err_bits); // R15
    end

    // receive alarm status; inputs come from the receive processor on this clock
    nxt_st.signal_loss_status = rx_signal_loss; // R1
    nxt_st.out_of_frame_status = rx_out_of_frame; // R4
    if (rx_out_of_frame != st_ff.frame_loss_status)
    begin
      if (st_ff.lof_timer == LOF_LIMIT)
      begin
        nxt_st.frame_loss_status = rx_out_of_frame; // R2 R3
        nxt_st.lof_timer = '0;
      end
      else
      begin
        nxt_st.lof_timer = st_ff.lof_timer + 1'b1; // R2 R3
      end
    end
    else
    begin
      nxt_st.lof_timer = '0; // R2 R3
    end

    // transmit byte path: overhead edits, AIS, scrambler, then signal loss
    ais_now = (tx_frame_start) ? st_ff.tx_control[TXC_AIS_BIT] : st_ff.ais_active; // R11
    tx_byte = tx_data;
    if (tx_b1_slot)
    begin
      tx_byte = st_ff.bip_last;
      if (st_ff.error_insert[EI_B1_INVERT_BIT])
      begin
        tx_byte = st_ff.bip_last ^ B1_INVERT; // R13
      end
    end
    if (tx_frame_start && st_ff.error_insert[EI_FRAMING_BIT])
    begin
      tx_byte = tx_data & A1_MSB_CLEAR; // R14
    end
    if (ais_now && !tx_soh)
    begin
      tx_byte = AIS_FILL; // R10
    end
    scr_reload = tx_valid && tx_no_scramble;
    scr_advance = tx_valid && !tx_no_scramble;
    if (tx_no_scramble || st_ff.tx_control[TXC_SCRAMBLE_DISABLE_BIT])
    begin
      tx_final = tx_byte; // R9
    end
    else
    begin
      tx_final = tx_scrambled; // R9
    end

    nxt_st.tx_out_valid = tx_valid;
    if (tx_valid)
    begin
      nxt_st.ais_active = ais_now; // R11
      // parity covers the frame as sent, before any forced signal loss
      if (tx_frame_start)
      begin
        nxt_st.bip_last = st_ff.bip_running;
        nxt_st.bip_running = tx_final;
      end
      else
      begin
        nxt_st.bip_running = st_ff.bip_running ^ tx_final;
      end
      nxt_st.tx_out_data = tx_final;
    end
    if (st_ff.error_insert[EI_SIGNAL_LOSS_BIT])
    begin
      nxt_st.tx_out_data = SIGNAL_LOSS_FILL; // R12
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.tx_control <= TX_CONTROL_RESET;
      st_ff.error_insert <= ERROR_INSERT_RESET;
      st_ff.section_parity_error_count <= COUNT_RESET; // R8
      st_ff.b1_accum <= COUNT_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  assign tx_out_valid = st_ff.tx_out_valid;
  assign tx_out_data = st_ff.tx_out_data;
  assign signal_loss_status = st_ff.signal_loss_status;
  assign frame_loss_status = st_ff.frame_loss_status;
  assign out_of_frame_status = st_ff.out_of_frame_status;

endmodule

// [rtl/sonet_soh_pkg.sv]
package sonet_soh_pkg;

  // clock and timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int LOF_PERSIST_MS = 3;
  localparam int LOF_PERSIST_CYCLES = LOF_PERSIST_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int LOF_TIMER_W = 19;
  localparam int SNAPSHOT_DELAY_NS = 1000;
  localparam int SNAPSHOT_DELAY_CYCLES = (SNAPSHOT_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SNAP_TIMER_W = 7;
  localparam logic [SNAP_TIMER_W-1:0] SNAP_TIMER_LOAD = SNAP_TIMER_W'(SNAPSHOT_DELAY_CYCLES - 1);

  // register indices; byte address is four times the index
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_MASTER = 6'h00;
  localparam logic [5:0] IDX_RX_STATUS = 6'h11;
  localparam logic [5:0] IDX_COUNT_LOW = 6'h12;
  localparam logic [5:0] IDX_COUNT_HIGH = 6'h13;
  localparam logic [5:0] IDX_TX_CONTROL = 6'h14;
  localparam logic [5:0] IDX_ERROR_INSERT = 6'h15;

  // field positions
  localparam int STATUS_LOS_BIT = 2;
  localparam int STATUS_LOF_BIT = 1;
  localparam int STATUS_OOF_BIT = 0;
  localparam int TXC_SCRAMBLE_DISABLE_BIT = 6;
  localparam int TXC_AIS_BIT = 0;
  localparam int EI_SIGNAL_LOSS_BIT = 2;
  localparam int EI_B1_INVERT_BIT = 1;
  localparam int EI_FRAMING_BIT = 0;

  // reset values and writable masks
  localparam logic [7:0] TX_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ERROR_INSERT_RESET = 8'h00;
  localparam logic [7:0] TX_CONTROL_MASK = 8'h41;
  localparam logic [7:0] ERROR_INSERT_MASK = 8'h07;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // transmit byte constants
  localparam logic [6:0] SCRAMBLER_SEED = 7'h7F;
  localparam logic [7:0] A1_MSB_CLEAR = 8'h7F;
  localparam logic [7:0] B1_INVERT = 8'hFF;
  localparam logic [7:0] AIS_FILL = 8'hFF;
  localparam logic [7:0] SIGNAL_LOSS_FILL = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [test/line_model.sv]
`timescale 1ns/1ps
module line_model
(
  input wire logic clock,
  output logic rx_signal_loss,
  output logic rx_out_of_frame,
  output logic rx_b1_err_valid,
  output wire logic [3:0] rx_b1_err_bits
);
  logic [3:0] err_n;
  logic [3:0] pat_ff;
  // count field keeps moving while unqualified so a stray count is caught
  assign rx_b1_err_bits = rx_b1_err_valid ? err_n : pat_ff;
  initial
  begin
    rx_signal_loss = 1'b0;
    rx_out_of_frame = 1'b0;
    rx_b1_err_valid = 1'b0;
    err_n = 4'h0;
    pat_ff = 4'h0;
  end
  always @(posedge clock)
    pat_ff <= pat_ff + 4'h5;
  task alarm(input logic los, input logic oof);
    rx_signal_loss <= los;
    rx_out_of_frame <= oof;
  endtask
  task errs(input int n, input logic [3:0] b);
    err_n <= b;
    rx_b1_err_valid <= 1'b1;
    repeat (n) @(posedge clock);
    rx_b1_err_valid <= 1'b0;
  endtask
endmodule

// [test/soh_props.sv]
`timescale 1ns/1ps
module soh_props #(
  parameter int lof_cycles = 20
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic rx_signal_loss,
  input wire logic rx_out_of_frame,
  input wire logic tx_valid,
  input wire logic tx_out_valid,
  input wire logic signal_loss_status,
  input wire logic frame_loss_status,
  input wire logic out_of_frame_status
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // cycles in a row where the receive state disagrees with the loss-of-frame flag
  logic [31:0] run_ff;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      run_ff <= '0;
    else if (rx_out_of_frame != frame_loss_status)
      run_ff <= run_ff + 32'h1;
    else
      run_ff <= '0;
  end
  a_los_follow: assert property (1 |=> signal_loss_status == $past(rx_signal_loss))
    else $error("loss of signal flag does not track input");
  a_oof_follow: assert property (1 |=> out_of_frame_status == $past(rx_out_of_frame))
    else $error("out of frame flag does not track input");
  a_lof_early: assert property ($changed(frame_loss_status) |-> run_ff >= lof_cycles)
    else $error("loss of frame flag changed too soon");
  a_lof_late: assert property (run_ff <= lof_cycles + 2)
    else $error("loss of frame flag changed too late");
  a_write_ans: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_read_ans: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read data missing");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  a_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_rdata_top: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_tx_pipe: assert property (1 |=> tx_out_valid == $past(tx_valid))
    else $error("transmit valid not one cycle late");
  cover property ($rose(frame_loss_status));
  cover property ($fell(frame_loss_status));
  cover property (bvalid && bresp == 2'h2);
endmodule
bind sonet_section_overhead_ctrl soh_props #(.lof_cycles(lof_cycles)) props (.*);

// [test/sonet_section_overhead_ctrl_test.sv]
`timescale 1ns/1ps
module sonet_section_overhead_ctrl_test;
  import sonet_soh_pkg::*;
  localparam int lof = 20;
  logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tx_valid, tx_out_valid;
  logic [7:0] awaddr, araddr, tx_data, tx_out_data;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [3:0] rx_b1_err_bits;
  logic [1:0] bresp, rresp;
  logic rx_signal_loss, rx_out_of_frame, rx_b1_err_valid;
  logic tx_frame_start, tx_soh, tx_no_scramble, tx_b1_slot;
  logic signal_loss_status, frame_loss_status, out_of_frame_status;
  int errors;
  int checks;
  sonet_section_overhead_ctrl #(.lof_cycles(lof)) dut (.*);
  line_model line (.*);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task final_report;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h000000, d};
    bready <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    while (!done)
    begin
      @(posedge clock);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        done = 1'b1;
        bready <= 1'b0;
        cmp(32'(bresp), 32'(er));
      end
    end
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic done;
    done = 1'b0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clock);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        done = 1'b1;
        rready <= 1'b0;
        cmp(rdata, {24'h000000, exp});
        cmp(32'(rresp), 32'(er));
      end
    end
    @(posedge clock);
  endtask
  // a frame start byte is also unscrambled section overhead
  task tx(input logic [7:0] d, input logic fs, input logic [7:0] exp);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_frame_start <= fs;
    tx_soh <= fs;
    tx_no_scramble <= fs;
    @(posedge clock);
    tx_valid <= 1'b0;
    @(posedge clock);
    cmp(32'(tx_out_valid), 32'h1);
    cmp(32'(tx_out_data), 32'(exp));
  endtask
  initial
  begin
    #300000;
    errors++;
    final_report;
  end
  initial
  begin
    errors = 0;
    checks = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, tx_data} = 24'h000000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    {tx_valid, tx_frame_start, tx_soh, tx_no_scramble, tx_b1_slot} = 5'h00;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd(8'h48, 8'h00, RESP_OKAY);
    rd(8'h4C, 8'h00, RESP_OKAY);
    rd(8'h50, 8'h00, RESP_OKAY);
    rd(8'h54, 8'h00, RESP_OKAY);
    wr(8'h80, 8'hFF, RESP_SLVERR);
    wr(8'h54, 8'hFF, RESP_OKAY);
    rd(8'h54, 8'h07, RESP_OKAY);
    wr(8'h54, 8'h00, RESP_OKAY);
    wr(8'h50, 8'hFF, RESP_OKAY);
    rd(8'h50, 8'h41, RESP_OKAY);
    tx(8'h12, 1'b0, 8'h12);
    tx(8'hF6, 1'b1, 8'hF6);
    tx(8'h12, 1'b0, 8'hFF);
    wr(8'h50, 8'h40, RESP_OKAY);
    tx(8'h12, 1'b0, 8'hFF);
    tx(8'hF6, 1'b1, 8'hF6);
    tx(8'h12, 1'b0, 8'h12);
    wr(8'h54, 8'h01, RESP_OKAY);
    tx(8'hF6, 1'b1, 8'h76);
    wr(8'h54, 8'h04, RESP_OKAY);
    tx(8'h12, 1'b0, 8'h00);
    tx(8'hF6, 1'b1, 8'h00);
    wr(8'h54, 8'h00, RESP_OKAY);
    wr(8'h50, 8'h00, RESP_OKAY);
    tx(8'hF6, 1'b1, 8'hF6);
    tx(8'h00, 1'b0, 8'hFE);
    wr(8'h54, 8'h02, RESP_OKAY);
    tx(8'hF6, 1'b1, 8'hF6);
    tx_b1_slot <= 1'b1;
    // parity of the frame above (F6, FE) is 08, inverted F7, then scrambled by key FE
    tx(8'h00, 1'b0, 8'h09);
    tx_b1_slot <= 1'b0;
    wr(8'h54, 8'h00, RESP_OKAY);
    wstrb <= 4'hE;
    wr(8'h50, 8'h01, RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h50, 8'h00, RESP_OKAY);
    line.alarm(1'b1, 1'b0);
    repeat (3) @(posedge clock);
    rd(8'h44, 8'h04, RESP_OKAY);
    line.alarm(1'b0, 1'b1);
    repeat (3) @(posedge clock);
    rd(8'h44, 8'h01, RESP_OKAY);
    repeat (lof + 5) @(posedge clock);
    rd(8'h44, 8'h03, RESP_OKAY);
    line.alarm(1'b0, 1'b0);
    repeat (3) @(posedge clock);
    rd(8'h44, 8'h02, RESP_OKAY);
    repeat (lof + 5) @(posedge clock);
    rd(8'h44, 8'h00, RESP_OKAY);
    // two short bursts whose sum exceeds the limit must not declare loss of frame
    line.alarm(1'b0, 1'b1);
    repeat (lof - 8) @(posedge clock);
    line.alarm(1'b0, 1'b0);
    @(posedge clock);
    line.alarm(1'b0, 1'b1);
    repeat (lof - 8) @(posedge clock);
    rd(8'h44, 8'h01, RESP_OKAY);
    line.alarm(1'b0, 1'b0);
    line.errs(20, 4'hF);
    wr(8'h00, 8'h00, RESP_OKAY);
    rd(8'h48, 8'h00, RESP_OKAY);
    repeat (110) @(posedge clock);
    rd(8'h48, 8'h2C, RESP_OKAY);
    rd(8'h4C, 8'h01, RESP_OKAY);
    wr(8'h4C, 8'hFF, RESP_OKAY);
    repeat (110) @(posedge clock);
    rd(8'h48, 8'h00, RESP_OKAY);
    line.errs(4400, 4'hF);
    wr(8'h48, 8'h00, RESP_OKAY);
    repeat (110) @(posedge clock);
    rd(8'h48, 8'hFF, RESP_OKAY);
    rd(8'h4C, 8'hFF, RESP_OKAY);
    final_report;
  end
endmodule
